// >>> ipgc_host.sv
// ipgc_host: host model that writes and reads the gain control registers.
// assumes the bench calls its tasks; all its outputs change on the falling edge of clk.
`timescale 1ns/100ps
module ipgc_host (
   // clock
   input  wire logic       clk,
   // register ports
   output logic            wr_en,
   output logic [6:0]      wr_addr,
   output logic [8:0]      wr_data,
   output logic [6:0]      rd_addr,
   input  wire logic [8:0] rd_data
);
   initial begin
      wr_en   = 1'b0;
      wr_addr = 7'h7F;
      wr_data = 9'h1FF;
      rd_addr = 7'h7F;
   end
   // ==========================================================
   // one write: strobe for one cycle, then scramble the released bus
   // manual gain is never written while the level controller owns a side
   task automatic wr(input logic [6:0] a, input logic [8:0] d);
      @(negedge clk);
      wr_en   = 1'b1;
      wr_addr = a;
      wr_data = d;
      @(negedge clk);
      wr_en   = 1'b0;
      wr_addr = ~a;
      wr_data = ~d;
   endtask : wr
   // ==========================================================
   // readback is combinational, so sample a little after the address moves
   task automatic rd(input logic [6:0] a, output logic [8:0] d);
      @(negedge clk);
      rd_addr = a;
      #1;
      d = rd_data;
   endtask : rd
endmodule : ipgc_host

// >>> ipgc_pkg.sv
// ipgc_pkg: register map, field positions, reset values and timing for the
// record input path gain control block.
// assumes a 7-bit register address and 9-bit data from the control port decoder.
package ipgc_pkg;
   // ==========================================================
   // register offsets
   localparam logic [6:0] ADDR_BIAS_POWER  = 7'h01;
   localparam logic [6:0] ADDR_INPUT_POWER = 7'h02;
   localparam logic [6:0] ADDR_ADC_CTL     = 7'h0E;
   localparam logic [6:0] ADDR_LEVEL_SEL   = 7'h20;
   localparam logic [6:0] ADDR_INPUT_CTL   = 7'h2C;
   localparam logic [6:0] ADDR_LEFT_VOL    = 7'h2D;
   localparam logic [6:0] ADDR_RIGHT_VOL   = 7'h2E;
   localparam logic [6:0] ADDR_LEFT_BOOST  = 7'h2F;
   localparam logic [6:0] ADDR_RIGHT_BOOST = 7'h30;
   // ==========================================================
   // field positions
   localparam int VOL_MUTE_BIT   = 6;
   localparam int VOL_ZC_BIT     = 7;
   localparam int VOL_UPD_BIT    = 8;
   localparam int BOOST_P20_BIT  = 8;
   localparam int BOOST_LINE_LSB = 4;
   localparam int PWR_MICB_BIT   = 4;
   localparam int PWR_ADCL_BIT   = 0;
   localparam int PWR_ADCR_BIT   = 1;
   localparam int PWR_BSTL_BIT   = 4;
   localparam int PWR_BSTR_BIT   = 5;
   localparam int ADC_INVL_BIT   = 0;
   localparam int ADC_INVR_BIT   = 1;
   localparam int ADC_OSR_BIT    = 3;
   localparam int ADC_CUT_LSB    = 4;
   localparam int ADC_MODE_BIT   = 7;
   localparam int ADC_HPF_BIT    = 8;
   localparam int LVL_SEL_LSB    = 7;
   localparam int INCTL_MBV_BIT  = 8;
   // ==========================================================
   // reset values
   localparam logic [8:0] RST_BIAS_POWER  = 9'h000;
   localparam logic [8:0] RST_INPUT_POWER = 9'h000;
   localparam logic [8:0] RST_ADC_CTL     = 9'h100;
   localparam logic [8:0] RST_LEVEL_SEL   = 9'h000;
   localparam logic [8:0] RST_INPUT_CTL   = 9'h033;
   localparam logic [8:0] RST_BOOST       = 9'h100;
   localparam logic [5:0] RST_GAIN        = 6'h10;
   // ==========================================================
   // zero-cross timeout
   localparam int TIMEOUT_US     = 1000;
   localparam int CLK_MHZ        = 100;
   localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;
   localparam int SAMPLE_W       = 24;
   // ==========================================================
   // per-channel controls handed to the analogue path
   typedef struct packed {
      logic [5:0] gain;
      logic       mute;
      logic       plus20;
      logic [2:0] aux_gain;
      logic [2:0] line_gain;
      logic       boost_on;
      logic       converter_on;
      logic       sample_invert;
   } ipgc_chan_t;
   typedef enum logic {IPGC_IDLE, IPGC_WAIT} ipgc_upd_t;
endpackage : ipgc_pkg

// >>> ipgc_top.sv
// ipgc_top: record input path register bank with double-buffered preamp gain.
// assumes wr_en/wr_addr/wr_data come from the control port decoder on clk,
// and that samples and level-controller gains are on clk as well.
`timescale 1ns/100ps
module ipgc_top
   import ipgc_pkg::*;
#(
   parameter int TIMEOUT_CNT = TIMEOUT_CYCLES
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // register write port
   input  wire logic                wr_en,
   input  wire logic [6:0]          wr_addr,
   input  wire logic [8:0]          wr_data,
   // register read port
   input  wire logic [6:0]          rd_addr,
   output logic      [8:0]          rd_data,
   // controlled-path samples and level controller gains
   input  wire logic                smp_valid,
   input  wire logic [SAMPLE_W-1:0] left_sample,
   input  wire logic [SAMPLE_W-1:0] right_sample,
   input  wire logic [5:0]          left_level_gain,
   input  wire logic [5:0]          right_level_gain,
   // analogue and filter controls
   output ipgc_chan_t               left_ctl,
   output ipgc_chan_t               right_ctl,
   output logic                     mic_bias_on,
   output logic                     mic_bias_oe_n,
   output logic                     mic_bias_level_sel,
   output logic                     oversample_ratio_sel,
   output logic                     highpass_on,
   output logic                     highpass_mode_sel,
   output logic [2:0]               highpass_cutoff_sel,
   output logic [1:0]               level_ctl_channel_select,
   output logic                     gain_pending
);
   // ==========================================================
   // register storage
   logic [8:0] bias_power_r, input_power_r, adc_ctl_r, level_sel_r, input_ctl_r;
   logic [8:0] boost_r [2];
   logic [7:0] vol_r   [2];
   logic [5:0] gain_act_r [2];
   logic [1:0] pend_r, zc_seen;
   logic       trig;
   logic [$clog2(TIMEOUT_CNT+1)-1:0] tmo_cnt_r;
   logic       tmo_pulse;
   logic [1:0] tmo_seen_r;
   logic [1:0] prev_sign_r;
   logic [SAMPLE_W-1:0] smp [2];
   logic [6:0] vol_addr [2];
   logic [6:0] bst_addr [2];

   assign smp[0] = left_sample;
   assign smp[1] = right_sample;
   assign vol_addr[0] = ADDR_LEFT_VOL;
   assign vol_addr[1] = ADDR_RIGHT_VOL;
   assign bst_addr[0] = ADDR_LEFT_BOOST;
   assign bst_addr[1] = ADDR_RIGHT_BOOST;

   always_ff @(posedge clk) begin
      if (rst) begin
         bias_power_r  <= RST_BIAS_POWER;
         input_power_r <= RST_INPUT_POWER;
         adc_ctl_r     <= RST_ADC_CTL;
         level_sel_r   <= RST_LEVEL_SEL;
         input_ctl_r   <= RST_INPUT_CTL;
      end else if (wr_en) begin
         unique case (wr_addr)
            ADDR_BIAS_POWER:  bias_power_r  <= wr_data;
            ADDR_INPUT_POWER: input_power_r <= wr_data;
            ADDR_ADC_CTL:     adc_ctl_r     <= wr_data;
            ADDR_LEVEL_SEL:   level_sel_r   <= wr_data;
            ADDR_INPUT_CTL:   input_ctl_r   <= wr_data;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // timeout tick; free-running so the force lands 1..2 periods after trigger
   assign tmo_pulse = (tmo_cnt_r == '0);
   always_ff @(posedge clk) begin
      if (rst || tmo_pulse) begin
         tmo_cnt_r <= ($clog2(TIMEOUT_CNT+1))'(TIMEOUT_CNT - 1);
      end else begin
         tmo_cnt_r <= tmo_cnt_r - 1'b1;
      end
   end

   // trigger from either volume register, bit 8 never stored
   assign trig = wr_en && wr_data[VOL_UPD_BIT] &&
                 (wr_addr == ADDR_LEFT_VOL || wr_addr == ADDR_RIGHT_VOL);
   assign gain_pending = |pend_r;

   // ==========================================================
   // per-channel volume, boost and update logic
   for (genvar c = 0; c < 2; c++) begin : g_ch
      logic sgn;
      logic zero;
      assign sgn  = smp[c][SAMPLE_W-1];
      assign zero = (smp[c] == '0);
      assign zc_seen[c] = smp_valid && (zero || (sgn != prev_sign_r[c]));

      always_ff @(posedge clk) begin
         if (rst) begin
            vol_r[c]   <= {2'b00, RST_GAIN};
            boost_r[c] <= RST_BOOST;
         end else if (wr_en) begin
            if (wr_addr == vol_addr[c]) vol_r[c] <= wr_data[7:0];
            if (wr_addr == bst_addr[c]) boost_r[c] <= wr_data;
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            prev_sign_r[c] <= 1'b0;
         end else if (smp_valid) begin
            prev_sign_r[c] <= sgn;
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            pend_r[c]     <= 1'b0;
            tmo_seen_r[c] <= 1'b0;
            gain_act_r[c] <= RST_GAIN;
         end else if (trig && !vol_r[c][VOL_ZC_BIT]) begin
            pend_r[c]     <= 1'b0;
            tmo_seen_r[c] <= 1'b0;
            gain_act_r[c] <= vol_r[c][5:0];
         end else if (trig) begin
            pend_r[c]     <= 1'b1;
            tmo_seen_r[c] <= 1'b0;
         end else if (pend_r[c] && (zc_seen[c] || (tmo_pulse && tmo_seen_r[c]))) begin
            pend_r[c]     <= 1'b0;
            tmo_seen_r[c] <= 1'b0;
            gain_act_r[c] <= vol_r[c][5:0];
         end else if (pend_r[c] && tmo_pulse) begin
            tmo_seen_r[c] <= 1'b1;
         end
      end
   end

   // ==========================================================
   // outputs; level control overrides manual gain on selected side
   assign level_ctl_channel_select = level_sel_r[LVL_SEL_LSB +: 2];
   always_comb begin
      left_ctl  = '0;
      right_ctl = '0;
      left_ctl.gain  = level_ctl_channel_select[1] ? left_level_gain  : gain_act_r[0];
      right_ctl.gain = level_ctl_channel_select[0] ? right_level_gain : gain_act_r[1];
      left_ctl.mute  = vol_r[0][VOL_MUTE_BIT];
      right_ctl.mute = vol_r[1][VOL_MUTE_BIT];
      left_ctl.plus20  = boost_r[0][BOOST_P20_BIT];
      right_ctl.plus20 = boost_r[1][BOOST_P20_BIT];
      left_ctl.aux_gain   = boost_r[0][2:0];
      right_ctl.aux_gain  = boost_r[1][2:0];
      left_ctl.line_gain  = boost_r[0][BOOST_LINE_LSB +: 3];
      right_ctl.line_gain = boost_r[1][BOOST_LINE_LSB +: 3];
      left_ctl.boost_on  = input_power_r[PWR_BSTL_BIT];
      right_ctl.boost_on = input_power_r[PWR_BSTR_BIT];
      left_ctl.converter_on  = input_power_r[PWR_ADCL_BIT];
      right_ctl.converter_on = input_power_r[PWR_ADCR_BIT];
      left_ctl.sample_invert  = adc_ctl_r[ADC_INVL_BIT];
      right_ctl.sample_invert = adc_ctl_r[ADC_INVR_BIT];
   end

   assign mic_bias_on          = bias_power_r[PWR_MICB_BIT];
   assign mic_bias_oe_n        = ~bias_power_r[PWR_MICB_BIT];
   assign mic_bias_level_sel   = input_ctl_r[INCTL_MBV_BIT];
   assign oversample_ratio_sel = adc_ctl_r[ADC_OSR_BIT];
   assign highpass_on          = adc_ctl_r[ADC_HPF_BIT];
   assign highpass_mode_sel    = adc_ctl_r[ADC_MODE_BIT];
   assign highpass_cutoff_sel  = adc_ctl_r[ADC_CUT_LSB +: 3];

   // readback: volume bit 8 reads zero since it is not stored
   always_comb begin
      unique case (rd_addr)
         ADDR_BIAS_POWER:  rd_data = bias_power_r;
         ADDR_INPUT_POWER: rd_data = input_power_r;
         ADDR_ADC_CTL:     rd_data = adc_ctl_r;
         ADDR_LEVEL_SEL:   rd_data = level_sel_r;
         ADDR_INPUT_CTL:   rd_data = input_ctl_r;
         ADDR_LEFT_VOL:    rd_data = {1'b0, vol_r[0]};
         ADDR_RIGHT_VOL:   rd_data = {1'b0, vol_r[1]};
         ADDR_LEFT_BOOST:  rd_data = boost_r[0];
         ADDR_RIGHT_BOOST: rd_data = boost_r[1];
         default:          rd_data = 9'h000;
      endcase
   end

   // ==========================================================
   // checks
   property p_reset_gain;
      @(posedge clk) $fell(rst) |-> gain_act_r[0] == RST_GAIN && gain_act_r[1] == RST_GAIN;
   endproperty
   a_reset_gain: assert property (p_reset_gain) else $error("gain reset wrong");
   property p_mute;
      @(posedge clk) disable iff (rst)
         wr_en && wr_addr == ADDR_LEFT_VOL |=> left_ctl.mute == $past(wr_data[VOL_MUTE_BIT]);
   endproperty
   a_mute: assert property (p_mute) else $error("mute not applied");
   property p_immediate;
      @(posedge clk) disable iff (rst)
         trig && !vol_r[0][VOL_ZC_BIT] |=> gain_act_r[0] == $past(vol_r[0][5:0]) && !pend_r[0];
   endproperty
   a_immediate: assert property (p_immediate) else $error("immediate update missed");
   property p_hold;
      @(posedge clk) disable iff (rst)
         !trig && !pend_r[0] |=> $stable(gain_act_r[0]);
   endproperty
   a_hold: assert property (p_hold) else $error("gain moved without trigger");
   property p_zc_apply;
      @(posedge clk) disable iff (rst)
         pend_r[1] && zc_seen[1] && !trig |=> !pend_r[1] && gain_act_r[1] == $past(vol_r[1][5:0]);
   endproperty
   a_zc_apply: assert property (p_zc_apply) else $error("zero cross update missed");
   property p_timeout;
      @(posedge clk) disable iff (rst)
         pend_r[0] && tmo_pulse && tmo_seen_r[0] && !trig |=> !pend_r[0];
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout did not force update");
   property p_tick;
      @(posedge clk) disable iff (rst) tmo_pulse |=> !tmo_pulse;
   endproperty
   a_tick: assert property (p_tick) else $error("timeout tick too long");
   property p_level;
      @(posedge clk) disable iff (rst)
         level_ctl_channel_select == 2'b11 |-> left_ctl.gain == left_level_gain
            && right_ctl.gain == right_level_gain;
   endproperty
   a_level: assert property (p_level) else $error("level control not steering gain");
   property p_bias;
      @(posedge clk) disable iff (rst)
         wr_en && wr_addr == ADDR_BIAS_POWER |=>
            mic_bias_oe_n == !$past(wr_data[PWR_MICB_BIT])
            && mic_bias_on == $past(wr_data[PWR_MICB_BIT]);
   endproperty
   a_bias: assert property (p_bias) else $error("bias enable mismatch");
   property p_hpf;
      @(posedge clk) $fell(rst) |-> highpass_on && !highpass_mode_sel && !oversample_ratio_sel;
   endproperty
   a_hpf: assert property (p_hpf) else $error("converter control reset wrong");
   c_immediate: cover property (@(posedge clk) disable iff (rst) trig && !vol_r[0][VOL_ZC_BIT]);
   c_zc: cover property (@(posedge clk) disable iff (rst) pend_r[0] && zc_seen[0]);
   c_tmo: cover property (@(posedge clk) disable iff (rst) pend_r[0] && tmo_pulse && tmo_seen_r[0]);
endmodule : ipgc_top

// >>> tb_input_path_gain_control.sv
// tb_input_path_gain_control: self-checking bench for the input path gain control.
// assumes ipgc_top and ipgc_host; short timeout parameter keeps the run brief.
`timescale 1ns/100ps
module tb_input_path_gain_control;
   import ipgc_pkg::*;
   localparam int TO = 20;
   typedef struct packed {logic [6:0] a; logic [8:0] d; logic [8:0] r; logic [8:0] o;} ipgc_row_t;
   logic                clk, rst, smp_valid, wr_en, gain_pending;
   logic [6:0]          wr_addr, rd_addr;
   logic [8:0]          wr_data, rd_data, got;
   logic [SAMPLE_W-1:0] left_sample, right_sample;
   logic [5:0]          left_level_gain, right_level_gain;
   ipgc_chan_t          left_ctl, right_ctl;
   logic                mic_bias_on, mic_bias_oe_n, mic_bias_level_sel, oversample_ratio_sel;
   logic                highpass_on, highpass_mode_sel;
   logic [2:0]          highpass_cutoff_sel;
   logic [1:0]          level_ctl_channel_select;
   int                  fails, samples_checked, n;
   // ==========================================================
   // rows: address, write data, expected readback, expected field outputs
   ipgc_row_t rst_tab [10] = '{
      '{ADDR_BIAS_POWER, 9'h000, 9'h000, 9'h000}, '{ADDR_INPUT_POWER, 9'h000, 9'h000, 9'h000},
      '{ADDR_ADC_CTL, 9'h000, 9'h100, 9'h100}, '{ADDR_LEVEL_SEL, 9'h000, 9'h000, 9'h000},
      '{ADDR_INPUT_CTL, 9'h000, 9'h033, 9'h000}, '{ADDR_LEFT_VOL, 9'h000, 9'h010, 9'h000},
      '{ADDR_RIGHT_VOL, 9'h000, 9'h010, 9'h000}, '{ADDR_LEFT_BOOST, 9'h000, 9'h100, 9'h100},
      '{ADDR_RIGHT_BOOST, 9'h000, 9'h100, 9'h100}, '{7'h05, 9'h000, 9'h000, 9'h000}};
   ipgc_row_t rows [20] = '{
      '{ADDR_BIAS_POWER, 9'h010, 9'h010, 9'h010}, '{ADDR_BIAS_POWER, 9'h000, 9'h000, 9'h000},
      '{ADDR_INPUT_POWER, 9'h033, 9'h033, 9'h033}, '{ADDR_INPUT_POWER, 9'h012, 9'h012, 9'h012},
      '{ADDR_ADC_CTL, 9'h0FB, 9'h0FB, 9'h0FB}, '{ADDR_ADC_CTL, 9'h151, 9'h151, 9'h151},
      '{ADDR_LEVEL_SEL, 9'h080, 9'h080, 9'h080}, '{ADDR_LEVEL_SEL, 9'h180, 9'h180, 9'h180},
      '{ADDR_LEVEL_SEL, 9'h000, 9'h000, 9'h000}, '{ADDR_INPUT_CTL, 9'h133, 9'h133, 9'h100},
      '{ADDR_INPUT_CTL, 9'h033, 9'h033, 9'h000}, '{ADDR_LEFT_BOOST, 9'h077, 9'h077, 9'h077},
      '{ADDR_LEFT_BOOST, 9'h141, 9'h141, 9'h141}, '{ADDR_RIGHT_BOOST, 9'h152, 9'h152, 9'h152},
      '{ADDR_RIGHT_BOOST, 9'h100, 9'h100, 9'h100}, '{7'h05, 9'h1FF, 9'h000, 9'h000},
      '{ADDR_LEFT_VOL, 9'h050, 9'h050, 9'h040}, '{ADDR_LEFT_VOL, 9'h010, 9'h010, 9'h000},
      '{ADDR_RIGHT_VOL, 9'h040, 9'h040, 9'h040}, '{ADDR_RIGHT_VOL, 9'h010, 9'h010, 9'h000}};
   ipgc_top #(.TIMEOUT_CNT(TO)) uut (
      .clk                      (clk),
      .rst                      (rst),
      .wr_en                    (wr_en),
      .wr_addr                  (wr_addr),
      .wr_data                  (wr_data),
      .rd_addr                  (rd_addr),
      .rd_data                  (rd_data),
      .smp_valid                (smp_valid),
      .left_sample              (left_sample),
      .right_sample             (right_sample),
      .left_level_gain          (left_level_gain),
      .right_level_gain         (right_level_gain),
      .left_ctl                 (left_ctl),
      .right_ctl                (right_ctl),
      .mic_bias_on              (mic_bias_on),
      .mic_bias_oe_n            (mic_bias_oe_n),
      .mic_bias_level_sel       (mic_bias_level_sel),
      .oversample_ratio_sel     (oversample_ratio_sel),
      .highpass_on              (highpass_on),
      .highpass_mode_sel        (highpass_mode_sel),
      .highpass_cutoff_sel      (highpass_cutoff_sel),
      .level_ctl_channel_select (level_ctl_channel_select),
      .gain_pending             (gain_pending)
   );
   ipgc_host host (.clk, .wr_en, .wr_addr, .wr_data, .rd_addr, .rd_data);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========================================================
   // outputs folded back into register layout so one row checks both
   function automatic logic [8:0] view(input logic [6:0] a);
      case (a)
         ADDR_BIAS_POWER:  view = {4'h0, mic_bias_on, 4'h0};
         ADDR_INPUT_POWER: view = {3'h0, right_ctl.boost_on, left_ctl.boost_on, 2'h0,
                                   right_ctl.converter_on, left_ctl.converter_on};
         ADDR_ADC_CTL:     view = {highpass_on, highpass_mode_sel, highpass_cutoff_sel,
                                   oversample_ratio_sel, 1'b0, right_ctl.sample_invert,
                                   left_ctl.sample_invert};
         ADDR_LEVEL_SEL:   view = {level_ctl_channel_select, 7'h00};
         ADDR_INPUT_CTL:   view = {mic_bias_level_sel, 8'h00};
         ADDR_LEFT_VOL:    view = {2'h0, left_ctl.mute, 6'h00};
         ADDR_RIGHT_VOL:   view = {2'h0, right_ctl.mute, 6'h00};
         ADDR_LEFT_BOOST:  view = {left_ctl.plus20, 1'b0, left_ctl.line_gain, 1'b0, left_ctl.aux_gain};
         ADDR_RIGHT_BOOST: view = {right_ctl.plus20, 1'b0, right_ctl.line_gain, 1'b0,
                                   right_ctl.aux_gain};
         default:          view = 9'h000;
      endcase
   endfunction : view
   // ==========================================================
   // compare and closing tasks
   task automatic chk_reg(input logic [8:0] g, input logic [8:0] e);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: register %h expected %h", $time, g, e);
      end
   endtask : chk_reg
   task automatic chk_gain(input logic [5:0] g, input logic [5:0] e);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: gain %h expected %h", $time, g, e);
      end
   endtask : chk_gain
   task automatic chk_bit(input logic g, input logic e);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: flag %b expected %b", $time, g, e);
      end
   endtask : chk_bit
   task automatic conclude;
      if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   task automatic check_row(input ipgc_row_t x, input logic w);
      logic [8:0] g;
      if (w) host.wr(x.a, x.d);
      host.rd(x.a, g);
      chk_reg(g, x.r);
      chk_reg(view(x.a), x.o);
   endtask : check_row
   // valid for one cycle, then the line shows the inverse so stale data cannot pass
   task automatic smp(input logic [SAMPLE_W-1:0] l, input logic [SAMPLE_W-1:0] r);
      @(negedge clk);
      smp_valid    = 1'b1;
      left_sample  = l;
      right_sample = r;
      @(negedge clk);
      smp_valid    = 1'b0;
      left_sample  = ~l;
      right_sample = ~r;
   endtask : smp
   task automatic wait_idle(input int lim, output int c);
      c = 0;
      while (gain_pending !== 1'b0 && c < lim) begin
         @(negedge clk);
         c++;
      end
      if (c >= lim) begin
         fails++;
         $display("wrong value at %0t: update still pending", $time);
         conclude();
      end
   endtask : wait_idle
   // ==========================================================
   // main sequence
   initial begin
      rst = 1'b1;
      smp_valid = 1'b0;
      left_sample = 24'h000100;
      right_sample = 24'h000400;
      left_level_gain = 6'h2A;
      right_level_gain = 6'h15;
      fails = 0;
      samples_checked = 0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      foreach (rst_tab[i]) check_row(rst_tab[i], 1'b0);
      chk_gain(left_ctl.gain, RST_GAIN);
      foreach (rows[i]) check_row(rows[i], 1'b1);
      host.wr(ADDR_LEFT_VOL, 9'h03F);
      chk_gain(left_ctl.gain, 6'h10);
      host.wr(ADDR_RIGHT_VOL, 9'h100);
      chk_gain(left_ctl.gain, 6'h3F);
      chk_gain(right_ctl.gain, 6'h10);
      host.rd(ADDR_RIGHT_VOL, got);
      chk_reg(got, 9'h000);
      host.wr(ADDR_LEFT_VOL, 9'h100);
      chk_gain(right_ctl.gain, 6'h00);
      smp(24'h000100, 24'h000400);
      host.wr(ADDR_LEFT_VOL, 9'h088);
      host.wr(ADDR_RIGHT_VOL, 9'h120);
      chk_bit(gain_pending, 1'b1);
      chk_gain(left_ctl.gain, 6'h3F);
      chk_gain(right_ctl.gain, 6'h00);
      smp(24'h000200, 24'h000400);
      chk_gain(left_ctl.gain, 6'h3F);
      smp(24'hFFFF00, 24'h000400);
      wait_idle(4, n);
      chk_gain(left_ctl.gain, 6'h08);
      host.wr(ADDR_LEFT_VOL, 9'h090);
      host.wr(ADDR_RIGHT_VOL, 9'h120);
      smp(24'h000000, 24'h000400);
      wait_idle(4, n);
      chk_gain(left_ctl.gain, 6'h10);
      host.wr(ADDR_LEFT_VOL, 9'h0A0);
      host.wr(ADDR_RIGHT_VOL, 9'h120);
      wait_idle(2 * TO + 4, n);
      chk_bit(n >= TO - 2, 1'b1);
      chk_bit(n <= 2 * TO + 1, 1'b1);
      chk_gain(left_ctl.gain, 6'h20);
      host.wr(ADDR_LEFT_VOL, 9'h020);
      host.wr(ADDR_RIGHT_VOL, 9'h0A5);
      host.wr(ADDR_RIGHT_VOL, 9'h1A5);
      chk_bit(gain_pending, 1'b1);
      chk_gain(right_ctl.gain, 6'h20);
      smp(24'h000100, 24'hFFF000);
      wait_idle(4, n);
      chk_gain(right_ctl.gain, 6'h25);
      chk_gain(left_ctl.gain, 6'h20);
      for (int s = 0; s < 4; s++) begin
         host.wr(ADDR_LEVEL_SEL, 9'(s) << 7);
         chk_gain(left_ctl.gain, s[1] ? 6'h2A : 6'h20);
         chk_gain(right_ctl.gain, s[0] ? 6'h15 : 6'h25);
      end
      host.wr(ADDR_BIAS_POWER, 9'h010);
      chk_bit(mic_bias_oe_n, 1'b0);
      host.wr(ADDR_BIAS_POWER, 9'h000);
      chk_bit(mic_bias_oe_n, 1'b1);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      foreach (rst_tab[i]) check_row(rst_tab[i], 1'b0);
      chk_gain(right_ctl.gain, RST_GAIN);
      conclude();
   end
endmodule : tb_input_path_gain_control
